// File: parallel_io_defines.vh
// Register offsets and reset values of the parallel I/O port bank
`ifndef PARALLEL_IO_DEFINES_VH
`define PARALLEL_IO_DEFINES_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define PORT_A_DIRECTION_OFF     12'h2C0
`define PORT_A_PIN_LEVELS_OFF    12'h2C2
`define PORT_A_OUTPUT_LATCH_OFF  12'h2C4
`define PORT_B_DIRECTION_OFF     12'h2C6
`define PORT_B_PIN_LEVELS_OFF    12'h2C8
`define PORT_B_OUTPUT_LATCH_OFF  12'h2CB
`define PORT_C_DIRECTION_OFF     12'h2CC
`define PORT_C_PIN_LEVELS_OFF    12'h2CE
`define PORT_C_OUTPUT_LATCH_OFF  12'h2D0
`define PORT_D_DIRECTION_OFF     12'h2D2
`define PORT_D_PIN_LEVELS_OFF    12'h2D4
`define PORT_D_OUTPUT_LATCH_OFF  12'h2D6
`define PORT_E_DIRECTION_OFF     12'h2D8
`define PORT_E_PIN_LEVELS_OFF    12'h2DA
`define PORT_E_OUTPUT_LATCH_OFF  12'h2DC
`define PORT_F_DIRECTION_OFF     12'h2EE
`define PORT_F_PIN_LEVELS_OFF    12'h2E0
`define PORT_F_OUTPUT_LATCH_OFF  12'h2E2
`define PORT_G_DIRECTION_OFF     12'h2E4
`define PORT_G_PIN_LEVELS_OFF    12'h2E6
`define PORT_G_OUTPUT_LATCH_OFF  12'h2E8
`define ANALOG_PIN_CONFIG_OFF    12'h300

// ****************************************
// Reset values; direction reset equals the implemented-bit mask
// ****************************************
`define PORT_A_DIRECTION_RST     16'hC600
`define PORT_B_DIRECTION_RST     16'hFFFF
`define PORT_C_DIRECTION_RST     16'hE00A
`define PORT_D_DIRECTION_RST     16'hFFFF
`define PORT_E_DIRECTION_RST     16'h03FF
`define PORT_F_DIRECTION_RST     16'h01FF
`define PORT_G_DIRECTION_RST     16'h03CF
`define OUTPUT_LATCH_RST         16'h0000
`define ANALOG_PIN_CONFIG_RST    16'h0000

// ****************************************
// Field positions and synchroniser stage count
// ****************************************
`define ANALOG_PORT_INDEX        1
`define PIN_SYNC_STAGES          2

`endif

// File: parallel_io_port_bank.v
// Parallel I/O port bank A to G with analog pin configuration
`include "parallel_io_defines.vh"
`default_nettype none

module parallel_io_port_bank #(
    parameter PORT_WIDTH = 16
) (
    // Clock and reset
    input  wire                      clock,
    input  wire                      rst,
    // Register port
    input  wire [11:0]               addr,
    input  wire [PORT_WIDTH-1:0]     wr_data,
    input  wire                      wr_strobe,
    input  wire                      rd_strobe,
    output reg  [PORT_WIDTH-1:0]     rd_data,
    // Pins, ports A..G packed from bit 0 upward
    input  wire [7*PORT_WIDTH-1:0]   pin_in,
    output wire [7*PORT_WIDTH-1:0]   pin_out,
    output wire [7*PORT_WIDTH-1:0]   pin_oe_n,
    // Peripheral sharing
    input  wire [7*PORT_WIDTH-1:0]   periph_active,
    input  wire [7*PORT_WIDTH-1:0]   periph_out,
    input  wire [7*PORT_WIDTH-1:0]   periph_oe_n,
    // Converter side, one bit per analog-capable pin of port B
    output wire [PORT_WIDTH-1:0]     analog_connect,
    output wire [PORT_WIDTH-1:0]     analog_input,
    output wire [PORT_WIDTH-1:0]     analog_samples_drive,
    output wire [PORT_WIDTH-1:0]     analog_drive_level
);

    // ****************************************
    // Address and mask tables
    // ****************************************
    localparam PORTS = 7;
    localparam [12*PORTS-1:0] DIR_OFFS = {
        `PORT_G_DIRECTION_OFF,
        `PORT_F_DIRECTION_OFF,
        `PORT_E_DIRECTION_OFF,
        `PORT_D_DIRECTION_OFF,
        `PORT_C_DIRECTION_OFF,
        `PORT_B_DIRECTION_OFF,
        `PORT_A_DIRECTION_OFF
    };
    localparam [12*PORTS-1:0] PIN_OFFS = {
        `PORT_G_PIN_LEVELS_OFF,
        `PORT_F_PIN_LEVELS_OFF,
        `PORT_E_PIN_LEVELS_OFF,
        `PORT_D_PIN_LEVELS_OFF,
        `PORT_C_PIN_LEVELS_OFF,
        `PORT_B_PIN_LEVELS_OFF,
        `PORT_A_PIN_LEVELS_OFF
    };
    localparam [12*PORTS-1:0] LAT_OFFS = {
        `PORT_G_OUTPUT_LATCH_OFF,
        `PORT_F_OUTPUT_LATCH_OFF,
        `PORT_E_OUTPUT_LATCH_OFF,
        `PORT_D_OUTPUT_LATCH_OFF,
        `PORT_C_OUTPUT_LATCH_OFF,
        `PORT_B_OUTPUT_LATCH_OFF,
        `PORT_A_OUTPUT_LATCH_OFF
    };
    // Implemented bits equal the direction reset values
    localparam [16*PORTS-1:0] IMPL = {
        `PORT_G_DIRECTION_RST,
        `PORT_F_DIRECTION_RST,
        `PORT_E_DIRECTION_RST,
        `PORT_D_DIRECTION_RST,
        `PORT_C_DIRECTION_RST,
        `PORT_B_DIRECTION_RST,
        `PORT_A_DIRECTION_RST
    };

    // ****************************************
    // Shared state
    // ****************************************
    reg  [PORT_WIDTH-1:0]        analog_pin_config_reg;
    reg  [PORT_WIDTH-1:0]        analog_pin_config_next;
    wire [7*PORT_WIDTH-1:0]      dir_all;
    wire [7*PORT_WIDTH-1:0]      lat_all;
    wire [7*PORT_WIDTH-1:0]      pin_rd_all;
    wire [PORT_WIDTH-1:0]        dir_b;
    wire [7*PORT_WIDTH-1:0]      analog_in_all;
    reg  [PORT_WIDTH-1:0]        rd_next;

    assign dir_b = dir_all[`ANALOG_PORT_INDEX*PORT_WIDTH +: PORT_WIDTH];

    // ****************************************
    // Analog configuration
    // ****************************************
    always @* begin
        analog_pin_config_next = analog_pin_config_reg;
        if (wr_strobe && addr == `ANALOG_PIN_CONFIG_OFF) begin
            analog_pin_config_next = wr_data;
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            analog_pin_config_reg <= `ANALOG_PIN_CONFIG_RST;
        end else begin
            analog_pin_config_reg <= analog_pin_config_next;
        end
    end

    // ****************************************
    // Converter side
    // ****************************************
    // Software is expected to set the direction bit too; otherwise applies
    // Only port B pins reach the converter
    genvar a;
    generate
        for (a = 0; a < PORT_WIDTH; a = a + 1) begin : analog_bit
            assign analog_input[a]         = analog_pin_config_reg[a] & dir_b[a];
            assign analog_connect[a]       = analog_pin_config_reg[a];
            assign analog_samples_drive[a] = analog_pin_config_reg[a] & ~dir_b[a];
            assign analog_drive_level[a]   = pin_out[`ANALOG_PORT_INDEX*PORT_WIDTH + a];
        end
    endgenerate
    // Widened to all ports so the per-port read mask stays uniform
    assign analog_in_all = {{(5*PORT_WIDTH){1'b0}}, analog_input, {PORT_WIDTH{1'b0}}};

    // ****************************************
    // Per-port registers, drivers and synchronisers
    // ****************************************
    genvar p;
    genvar b;
    generate
        for (p = 0; p < PORTS; p = p + 1) begin : port
            localparam [PORT_WIDTH-1:0] MASK = IMPL[p*16 +: 16];
            reg  [PORT_WIDTH-1:0] dir_reg;
            reg  [PORT_WIDTH-1:0] dir_next;
            reg  [PORT_WIDTH-1:0] lat_reg;
            reg  [PORT_WIDTH-1:0] lat_next;
            reg  [PORT_WIDTH-1:0] sync1_reg;
            reg  [PORT_WIDTH-1:0] sync2_reg;
            wire                  dir_hit;
            wire                  lat_hit;

            assign dir_hit = wr_strobe && addr == DIR_OFFS[p*12 +: 12];
            assign lat_hit = wr_strobe && (addr == LAT_OFFS[p*12 +: 12] ||
                                           addr == PIN_OFFS[p*12 +: 12]);

            // ****************************************
            // Direction register
            // ****************************************
            always @* begin
                dir_next = dir_reg;
                if (dir_hit) begin
                    dir_next = wr_data & MASK;
                end
            end

            // Direction resets to its implemented mask, so all pins start as inputs
            always @(posedge clock or posedge rst) begin
                if (rst) begin
                    dir_reg <= MASK;
                end else begin
                    dir_reg <= dir_next;
                end
            end

            // ****************************************
            // Output latch
            // ****************************************
            // Pin-level writes land in the latch; the pins are never written
            always @* begin
                lat_next = lat_reg;
                if (lat_hit) begin
                    lat_next = wr_data & MASK;
                end
            end

            always @(posedge clock or posedge rst) begin
                if (rst) begin
                    lat_reg <= `OUTPUT_LATCH_RST;
                end else begin
                    lat_reg <= lat_next;
                end
            end

            // ****************************************
            // Synchroniser
            // ****************************************
            // Two stages because pins are asynchronous to the clock
            always @(posedge clock or posedge rst) begin
                if (rst) begin
                    sync1_reg <= {PORT_WIDTH{1'b0}};
                end else begin
                    sync1_reg <= pin_in[p*PORT_WIDTH +: PORT_WIDTH];
                end
            end

            always @(posedge clock or posedge rst) begin
                if (rst) begin
                    sync2_reg <= {PORT_WIDTH{1'b0}};
                end else begin
                    sync2_reg <= sync1_reg;
                end
            end

            // ****************************************
            // Pin drive and pin read
            // ****************************************
            for (b = 0; b < PORT_WIDTH; b = b + 1) begin : pin_bit
                if (MASK[b]) begin : live
                    assign pin_out[p*PORT_WIDTH + b] = periph_active[p*PORT_WIDTH + b] ?
                        periph_out[p*PORT_WIDTH + b] : lat_reg[b];
                    assign pin_oe_n[p*PORT_WIDTH + b] = periph_active[p*PORT_WIDTH + b] ?
                        periph_oe_n[p*PORT_WIDTH + b] : dir_reg[b];
                    assign pin_rd_all[p*PORT_WIDTH + b] =
                        sync2_reg[b] & ~analog_in_all[p*PORT_WIDTH + b];
                end else begin : dead
                    // Disabled bits never drive and read as zero
                    assign pin_out[p*PORT_WIDTH + b]    = 1'b0;
                    assign pin_oe_n[p*PORT_WIDTH + b]   = 1'b1;
                    assign pin_rd_all[p*PORT_WIDTH + b] = 1'b0;
                end
            end

            // ****************************************
            // Values seen by the read path
            // ****************************************
            assign dir_all[p*PORT_WIDTH +: PORT_WIDTH] = dir_reg;
            assign lat_all[p*PORT_WIDTH +: PORT_WIDTH] = lat_reg;
        end
    endgenerate

    // ****************************************
    // Read path; data stand for one cycle only
    // ****************************************
    // Unmapped addresses fall to zero
    always @* begin
        rd_next = {PORT_WIDTH{1'b0}};
        case (addr)
            `PORT_A_DIRECTION_OFF: begin
                rd_next = dir_all[0 +: PORT_WIDTH];
            end
            `PORT_A_PIN_LEVELS_OFF: begin
                rd_next = pin_rd_all[0 +: PORT_WIDTH];
            end
            `PORT_A_OUTPUT_LATCH_OFF: begin
                rd_next = lat_all[0 +: PORT_WIDTH];
            end

            `PORT_B_DIRECTION_OFF: begin
                rd_next = dir_all[PORT_WIDTH +: PORT_WIDTH];
            end
            `PORT_B_PIN_LEVELS_OFF: begin
                rd_next = pin_rd_all[PORT_WIDTH +: PORT_WIDTH];
            end
            // Port B latch sits at an odd offset, kept as mapped
            `PORT_B_OUTPUT_LATCH_OFF: begin
                rd_next = lat_all[PORT_WIDTH +: PORT_WIDTH];
            end

            `PORT_C_DIRECTION_OFF: begin
                rd_next = dir_all[2*PORT_WIDTH +: PORT_WIDTH];
            end
            `PORT_C_PIN_LEVELS_OFF: begin
                rd_next = pin_rd_all[2*PORT_WIDTH +: PORT_WIDTH];
            end
            `PORT_C_OUTPUT_LATCH_OFF: begin
                rd_next = lat_all[2*PORT_WIDTH +: PORT_WIDTH];
            end

            `PORT_D_DIRECTION_OFF: begin
                rd_next = dir_all[3*PORT_WIDTH +: PORT_WIDTH];
            end
            `PORT_D_PIN_LEVELS_OFF: begin
                rd_next = pin_rd_all[3*PORT_WIDTH +: PORT_WIDTH];
            end
            `PORT_D_OUTPUT_LATCH_OFF: begin
                rd_next = lat_all[3*PORT_WIDTH +: PORT_WIDTH];
            end

            `PORT_E_DIRECTION_OFF: begin
                rd_next = dir_all[4*PORT_WIDTH +: PORT_WIDTH];
            end
            `PORT_E_PIN_LEVELS_OFF: begin
                rd_next = pin_rd_all[4*PORT_WIDTH +: PORT_WIDTH];
            end
            `PORT_E_OUTPUT_LATCH_OFF: begin
                rd_next = lat_all[4*PORT_WIDTH +: PORT_WIDTH];
            end

            `PORT_F_DIRECTION_OFF: begin
                rd_next = dir_all[5*PORT_WIDTH +: PORT_WIDTH];
            end
            `PORT_F_PIN_LEVELS_OFF: begin
                rd_next = pin_rd_all[5*PORT_WIDTH +: PORT_WIDTH];
            end
            `PORT_F_OUTPUT_LATCH_OFF: begin
                rd_next = lat_all[5*PORT_WIDTH +: PORT_WIDTH];
            end

            `PORT_G_DIRECTION_OFF: begin
                rd_next = dir_all[6*PORT_WIDTH +: PORT_WIDTH];
            end
            `PORT_G_PIN_LEVELS_OFF: begin
                rd_next = pin_rd_all[6*PORT_WIDTH +: PORT_WIDTH];
            end
            `PORT_G_OUTPUT_LATCH_OFF: begin
                rd_next = lat_all[6*PORT_WIDTH +: PORT_WIDTH];
            end

            `ANALOG_PIN_CONFIG_OFF: begin
                rd_next = analog_pin_config_reg;
            end
            default: begin
                rd_next = {PORT_WIDTH{1'b0}};
            end
        endcase
    end

    // Zero outside a read, so the read bus can be merged by OR
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_data <= {PORT_WIDTH{1'b0}};
        end else if (rd_strobe) begin
            rd_data <= rd_next;
        end else begin
            rd_data <= {PORT_WIDTH{1'b0}};
        end
    end

endmodule // parallel_io_port_bank

`default_nettype wire

// File: io_bank_properties.sv
// Concurrent checks on the port bank's register port, pins and converter side
`default_nettype none
module io_bank_properties #(parameter PORT_WIDTH = 16) (
    // Clock, reset, register port
    input wire logic                    clock, rst, wr_strobe, rd_strobe,
    input wire logic [11:0]             addr,
    input wire logic [PORT_WIDTH-1:0]   wr_data, rd_data,
    // Pins and peripheral sharing
    input wire logic [7*PORT_WIDTH-1:0] pin_in, pin_out, pin_oe_n,
    input wire logic [7*PORT_WIDTH-1:0] periph_active, periph_out, periph_oe_n,
    // Converter side
    input wire logic [PORT_WIDTH-1:0]   analog_connect, analog_input,
    input wire logic [PORT_WIDTH-1:0]   analog_samples_drive, analog_drive_level
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam [111:0] IMPL = {16'h03CF, 16'h01FF, 16'h03FF, 16'hFFFF, 16'hE00A,
                               16'hFFFF, 16'hC600};
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    rd_idle_a: assert property (!rd_strobe |=> rd_data == 0)
        else $error("read data not zero outside a read");
    rd_unimpl_a: assert property (rd_strobe && addr == 12'h2CC |=> (rd_data & ~16'hE00A) == 0)
        else $error("unimplemented direction bit read nonzero");
    pin_delay_a: assert property (rd_strobe && addr == 12'h2C2
        |=> rd_data == ($past(pin_in[15:0], 3) & 16'hC600))
        else $error("pin read not two stages late");
    pin_zero_a: assert property (rd_strobe && addr == 12'h2C8
        |=> (rd_data & $past(analog_input)) == 0)
        else $error("analog input pin read nonzero");
    dir_write_a: assert property (wr_strobe && addr == 12'h2C6 && periph_active[31:16] == 0
        |=> pin_oe_n[31:16] == $past(wr_data))
        else $error("direction write not seen on enables");
    oe_unimpl_a: assert property ((pin_oe_n | IMPL) == '1)
        else $error("unimplemented pin driven");
    periph_oe_a: assert property (((pin_oe_n ^ periph_oe_n) & periph_active & IMPL) == 0)
        else $error("peripheral does not own enable");
    periph_data_a: assert property (((pin_out ^ periph_out) & periph_active & IMPL) == 0)
        else $error("peripheral does not own data");
    analog_in_a: assert property (periph_active[31:16] == 0
        |-> analog_input == (analog_connect & pin_oe_n[31:16]))
        else $error("analog input select wrong");
    analog_drive_a: assert property (periph_active[31:16] == 0
        |-> analog_samples_drive == (analog_connect & ~pin_oe_n[31:16])
        && ((analog_drive_level ^ pin_out[31:16]) & analog_samples_drive) == 0)
        else $error("driven analog pin level wrong");
    analog_dig_a: assert property (((analog_input | analog_samples_drive) & ~analog_connect) == 0)
        else $error("digital pin routed to converter");
endmodule // io_bank_properties
bind parallel_io_port_bank io_bank_properties #(.PORT_WIDTH(PORT_WIDTH)) chk (
    .clock(clock), .rst(rst), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .addr(addr),
    .wr_data(wr_data), .rd_data(rd_data), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .periph_active(periph_active), .periph_out(periph_out),
    .periph_oe_n(periph_oe_n), .analog_connect(analog_connect), .analog_input(analog_input),
    .analog_samples_drive(analog_samples_drive), .analog_drive_level(analog_drive_level));
`default_nettype wire

// File: pin_model.sv
// Far side of the pins: driven pins loop back, released pins show the outside level
`default_nettype none
module pin_model (
    // From the bank
    input wire logic [111:0] pin_out, pin_oe_n,
    // Outside world, and back into the bank
    input wire logic [111:0] outside,
    output logic     [111:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Driven level comes back, so a pin-level read sees the pin's own drive
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & outside);
endmodule // pin_model
`default_nettype wire

// File: parallel_io_port_bank_bench.sv
// Register-level bench for the parallel I/O port bank
`default_nettype none
module parallel_io_port_bank_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic         clock = 0, rst = 1, wr_strobe = 0, rd_strobe = 0;
    logic [11:0]  addr = 0;
    logic [15:0]  wr_data = 0;
    wire  [15:0]  rd_data;
    logic [111:0] outside = '1, periph_active = 0, periph_out = '1, periph_oe_n = 0;
    wire  [111:0] pin_in, pin_out, pin_oe_n;
    int           n_errors = 0, tests_run = 0;
    logic [11:0]  dir_off [7] = '{12'h2C0, 12'h2C6, 12'h2CC, 12'h2D2, 12'h2D8, 12'h2EE, 12'h2E4};
    logic [15:0]  dir_rst [7] = '{16'hC600, 16'hFFFF, 16'hE00A, 16'hFFFF, 16'h03FF, 16'h01FF,
                                  16'h03CF};
    always #10 clock = ~clock;
    parallel_io_port_bank dut (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .periph_active(periph_active),
        .periph_out(periph_out), .periph_oe_n(periph_oe_n), .analog_connect(),
        .analog_input(), .analog_samples_drive(), .analog_drive_level());
    pin_model far (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .outside(outside), .pin_in(pin_in));
    task wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_strobe <= 1'b1;
        @(posedge clock);
        wr_strobe <= 1'b0;
    endtask
    // Idle cycles first so a pin read never races the synchroniser
    task rd(input logic [11:0] a, input logic [15:0] e);
        repeat (3) @(posedge clock);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clock);
        rd_strobe <= 1'b0;
        @(negedge clock);
        tests_run++;
        if (rd_data !== e) begin
            $display("Error %0t: read %h gave %h, want %h", $time, a, rd_data, e);
            n_errors++;
        end
    endtask
    task end_of_test;
        $display("Checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) rd(dir_off[i], dir_rst[i]);
        rd(12'h2C4, 16'h0000);
        rd(12'h2C2, 16'hC600);
        wr(12'h2D0, 16'hFFFF);
        rd(12'h2D0, 16'hE00A);
        wr(12'h2CA, 16'h1234);
        rd(12'h2CA, 16'h0000);
        wr(12'h2C0, 16'h0000);
        wr(12'h2C4, 16'h4200);
        rd(12'h2C2, 16'h4200);
        @(posedge clock) periph_active <= 112'h8000;
        rd(12'h2C2, 16'hC200);
        wr(12'h300, 16'h00FF);
        rd(12'h2C8, 16'hFF00);
        wr(12'h2C6, 16'hFFF0);
        wr(12'h2C8, 16'h0005);
        rd(12'h2CB, 16'h0005);
        rd(12'h2C8, 16'hFF05);
        rd(12'h300, 16'h00FF);
        end_of_test;
    end
    // Hang guard
    initial begin
        #1000000;
        n_errors++;
        end_of_test;
    end
endmodule // parallel_io_port_bank_bench
`default_nettype wire
